// ### core/rxpc_pkg.sv
// Package of constants and types for the receive payload conditioner
package rxpc_pkg;

    // Directly addressed registers
    localparam logic [7:0] ADDR_CONFIG      = 8'h50;
    localparam logic [7:0] ADDR_STATUS      = 8'h51;
    localparam logic [7:0] ADDR_ADDR_CTRL   = 8'h52;
    localparam logic [7:0] ADDR_DATA_BUF    = 8'h53;

    // Field positions
    localparam int BIT_BUSY           = 7;
    localparam int BIT_DIRECTION      = 7;
    localparam int BIT_PER_CHANNEL_ENABLE           = 0;
    localparam int BIT_INVERT         = 7;
    localparam int BIT_DATA_TRUNK     = 6;
    localparam int BIT_MILLIWATT      = 5;
    localparam int BIT_MSB_FLIP       = 4;
    localparam int BIT_TEST           = 3;
    localparam int BIT_CLK_ENABLE     = 2;
    localparam int BIT_FIX            = 1;
    localparam int BIT_FIXED_LEVEL    = 0;
    localparam int BIT_SIG_TRUNK      = 7;
    localparam int BIT_SIGNALING      = 0;

    // Indirect map
    localparam logic [6:0] IND_CFG_FIRST   = 7'h01;
    localparam logic [6:0] IND_TRUNK_FIRST = 7'h19;
    localparam logic [6:0] IND_SIG_FIRST   = 7'h31;
    localparam logic [6:0] IND_LAST        = 7'h48;
    localparam int         NUM_CHANNELS    = 24;
    localparam logic [4:0] LAST_CHANNEL    = 5'h17;

    // Reset values
    localparam logic [7:0] RESET_BYTE      = 8'h00;
    localparam logic [3:0] RESET_NIBBLE    = 4'h0;

    // Access cycle timing
    localparam int         ACCESS_TIME_NS  = 640;
    localparam int         CLK_PERIOD_NS   = 5;
    localparam int         ACCESS_CYCLES   = (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] ACCESS_COUNT    = 8'(ACCESS_CYCLES);

    // Milliwatt sequence length
    localparam logic [2:0] MW_LAST_PHASE   = 3'h7;

    // One channel slot on the stream
    typedef struct packed {
        logic       valid;
        logic [4:0] channel;
        logic [7:0] data;
        logic [3:0] signaling;
    } rxpc_slot_t;

    // Processor port request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rxpc_bus_t;

endpackage : rxpc_pkg

// ### core/rxpc_conditioner.sv
// Receive per-channel payload conditioner with indirect register window
// Notes on behaviour
// - Busy flag sits in status bit 7
// - Access cycle lasts 640 ns, then busy drops
// - Valid address write starts an access cycle
// - Bit 7 chooses read or write direction
// - Address field valid from 01H to 48H
// - Read result appears in buffer after 640 ns
// - Config, data trunk, signaling trunk blocks
// - Invert and msb_flip choose inversion pattern
// - Data trunk replaces byte with stored code
// - Milliwatt enable replaces byte with milliwatt pattern
// - Test bit extracts or inserts generator pattern
// - Test channels form one continuous stream
// - Fractional mode gates clock per channel enable
// - Fix bit forces signaling bit to level
// - Extract, trunk, milliwatt, generator, invert, fix
// - Signaling trunk replaces nibble with stored value
// - Per-channel functions only while enable set
`timescale 1ns/10ps

module rxpc_conditioner (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire rxpc_pkg::rxpc_bus_t  bus_req,
    output logic [7:0]                bus_rdata,
    input  wire rxpc_pkg::rxpc_slot_t slot_in,
    output rxpc_pkg::rxpc_slot_t      slot_out,
    input  wire logic                 rx_pattern_source_sel,
    output logic                      detector_valid,
    output logic [7:0]                detector_data,
    input  wire logic [7:0]           generator_data,
    output logic                      generator_take,
    input  wire logic                 fractional_mode,
    input  wire logic                 rx_bit_clock_in,
    output logic                      rx_serial_clock_out
);

    logic [7:0] channel_config [rxpc_pkg::NUM_CHANNELS];
    logic [7:0] trunk_code_byte [rxpc_pkg::NUM_CHANNELS];
    logic [7:0] signaling_trunk [rxpc_pkg::NUM_CHANNELS];

    logic       per_channel_enable;
    logic       busy;
    logic [7:0] busy_count;
    logic       direction_select;
    logic [6:0] indirect_addr;
    logic [7:0] data_buffer;
    logic [2:0] milliwatt_phase;
    logic       clock_gate;

    logic       ctrl_write;
    logic       access_done;
    logic [7:0] read_value;
    logic [7:0] cfg;
    logic [7:0] sig_cfg;
    logic       test_active;
    logic [7:0] next_data;
    logic [3:0] next_signaling;

    // Address in the window, and the channel index within its block
    function automatic logic addr_valid(input logic [6:0] a);
        addr_valid = (a >= rxpc_pkg::IND_CFG_FIRST) && (a <= rxpc_pkg::IND_LAST);
    endfunction : addr_valid

    function automatic logic [4:0] block_index(input logic [6:0] a);
        logic [6:0] off;
        off = 7'h00;
        if (a >= rxpc_pkg::IND_SIG_FIRST) begin
            off = a - rxpc_pkg::IND_SIG_FIRST;
        end else if (a >= rxpc_pkg::IND_TRUNK_FIRST) begin
            off = a - rxpc_pkg::IND_TRUNK_FIRST;
        end else begin
            off = a - rxpc_pkg::IND_CFG_FIRST;
        end
        block_index = off[4:0];
    endfunction : block_index

    // Digital milliwatt, eight samples per cycle
    function automatic logic [7:0] milliwatt_code(input logic [2:0] phase);
        case (phase)
            3'h0:    milliwatt_code = 8'h1e;
            3'h1:    milliwatt_code = 8'h0b;
            3'h2:    milliwatt_code = 8'h0b;
            3'h3:    milliwatt_code = 8'h1e;
            3'h4:    milliwatt_code = 8'h9e;
            3'h5:    milliwatt_code = 8'h8b;
            3'h6:    milliwatt_code = 8'h8b;
            default: milliwatt_code = 8'h9e;
        endcase
    endfunction : milliwatt_code

    // New requests during a cycle are dropped, the host must poll first
    assign ctrl_write  = bus_req.wr && (bus_req.addr == rxpc_pkg::ADDR_ADDR_CTRL)
                         && !busy;
    assign access_done = busy && (busy_count == 8'h01);

    // Configuration register holding the global enable
    always_ff @(posedge clk) begin
        if (rst) begin
            per_channel_enable <= 1'b0;
        end else if (bus_req.wr && bus_req.addr == rxpc_pkg::ADDR_CONFIG) begin
            per_channel_enable <= bus_req.wdata[rxpc_pkg::BIT_PER_CHANNEL_ENABLE];
        end
    end

    // Address/control register; start only on a valid address
    always_ff @(posedge clk) begin
        if (rst) begin
            direction_select <= 1'b0;
            indirect_addr    <= 7'h00;
        end else if (ctrl_write) begin
            direction_select <= bus_req.wdata[rxpc_pkg::BIT_DIRECTION];
            indirect_addr    <= bus_req.wdata[6:0];
        end
    end

    // Busy flag and access timer
    always_ff @(posedge clk) begin
        if (rst) begin
            busy       <= 1'b0;
            busy_count <= 8'h00;
        end else if (ctrl_write && addr_valid(bus_req.wdata[6:0])) begin
            busy       <= 1'b1;
            busy_count <= rxpc_pkg::ACCESS_COUNT;
        end else if (busy) begin
            busy_count <= busy_count - 8'h01;
            if (access_done) begin
                busy <= 1'b0;
            end
        end
    end

    // Indirect read value
    always_comb begin
        read_value = rxpc_pkg::RESET_BYTE;
        if (indirect_addr >= rxpc_pkg::IND_SIG_FIRST) begin
            read_value = signaling_trunk[block_index(indirect_addr)];
        end else if (indirect_addr >= rxpc_pkg::IND_TRUNK_FIRST) begin
            read_value = trunk_code_byte[block_index(indirect_addr)];
        end else begin
            read_value = channel_config[block_index(indirect_addr)];
        end
    end

    // Data buffer; locked while an access runs so the write byte holds
    always_ff @(posedge clk) begin
        if (rst) begin
            data_buffer <= rxpc_pkg::RESET_BYTE;
        end else if (access_done && direction_select) begin
            data_buffer <= read_value;
        end else if (bus_req.wr && bus_req.addr == rxpc_pkg::ADDR_DATA_BUF && !busy) begin
            data_buffer <= bus_req.wdata;
        end
    end

    // Indirect register arrays, written at the end of the cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < rxpc_pkg::NUM_CHANNELS; i++) begin
                channel_config[i]  <= rxpc_pkg::RESET_BYTE;
                trunk_code_byte[i] <= rxpc_pkg::RESET_BYTE;
                signaling_trunk[i] <= rxpc_pkg::RESET_BYTE;
            end
        end else if (access_done && !direction_select) begin
            if (indirect_addr >= rxpc_pkg::IND_SIG_FIRST) begin
                signaling_trunk[block_index(indirect_addr)] <= {data_buffer[7], 3'h0,
                                                                 data_buffer[3:0]};
            end else if (indirect_addr >= rxpc_pkg::IND_TRUNK_FIRST) begin
                trunk_code_byte[block_index(indirect_addr)] <= data_buffer;
            end else begin
                channel_config[block_index(indirect_addr)] <= data_buffer;
            end
        end
    end

    // Register read port
    always_ff @(posedge clk) begin
        if (rst) begin
            bus_rdata <= rxpc_pkg::RESET_BYTE;
        end else if (bus_req.rd) begin
            case (bus_req.addr)
                rxpc_pkg::ADDR_CONFIG:    bus_rdata <= {7'h00, per_channel_enable};
                rxpc_pkg::ADDR_STATUS:    bus_rdata <= {busy, 7'h00};
                rxpc_pkg::ADDR_ADDR_CTRL: bus_rdata <= {direction_select, indirect_addr};
                rxpc_pkg::ADDR_DATA_BUF:  bus_rdata <= data_buffer;
                default:                  bus_rdata <= rxpc_pkg::RESET_BYTE;
            endcase
        end
    end

    // Per-channel settings of the slot now arriving
    always_comb begin
        cfg     = rxpc_pkg::RESET_BYTE;
        sig_cfg = rxpc_pkg::RESET_BYTE;
        if (slot_in.channel <= rxpc_pkg::LAST_CHANNEL) begin
            cfg     = channel_config[slot_in.channel];
            sig_cfg = signaling_trunk[slot_in.channel];
        end
    end

    // Pattern engine sees only marked slots, so gaps vanish from its stream
    assign test_active    = slot_in.valid && per_channel_enable && cfg[rxpc_pkg::BIT_TEST];
    assign generator_take = test_active && rx_pattern_source_sel;

    // Output selection in priority order
    always_comb begin
        next_data      = slot_in.data;
        next_signaling = slot_in.signaling;
        if (per_channel_enable) begin
            if (cfg[rxpc_pkg::BIT_TEST] && !rx_pattern_source_sel) begin
                next_data = slot_in.data;
            end else if (cfg[rxpc_pkg::BIT_DATA_TRUNK]) begin
                next_data = trunk_code_byte[slot_in.channel];
            end else if (cfg[rxpc_pkg::BIT_MILLIWATT]) begin
                next_data = milliwatt_code(milliwatt_phase);
            end else if (cfg[rxpc_pkg::BIT_TEST]) begin
                next_data = generator_data;
            end else begin
                case ({cfg[rxpc_pkg::BIT_INVERT], cfg[rxpc_pkg::BIT_MSB_FLIP]})
                    2'b01:   next_data = slot_in.data ^ 8'h80;
                    2'b10:   next_data = ~slot_in.data;
                    2'b11:   next_data = slot_in.data ^ 8'h7f;
                    default: next_data = slot_in.data;
                endcase
                if (cfg[rxpc_pkg::BIT_FIX]) begin
                    next_data[rxpc_pkg::BIT_SIGNALING] = cfg[rxpc_pkg::BIT_FIXED_LEVEL];
                end
            end
            if (sig_cfg[rxpc_pkg::BIT_SIG_TRUNK]) begin
                next_signaling = sig_cfg[3:0];
            end
        end
    end

    // Registered slot output
    always_ff @(posedge clk) begin
        if (rst) begin
            slot_out <= '0;
        end else begin
            slot_out.valid     <= slot_in.valid;
            slot_out.channel   <= slot_in.channel;
            slot_out.data      <= next_data;
            slot_out.signaling <= next_signaling;
        end
    end

    // Extraction to the detector, one byte per marked slot
    always_ff @(posedge clk) begin
        if (rst) begin
            detector_valid <= 1'b0;
            detector_data  <= rxpc_pkg::RESET_BYTE;
        end else begin
            detector_valid <= test_active && !rx_pattern_source_sel;
            if (test_active && !rx_pattern_source_sel) begin
                detector_data <= slot_in.data;
            end
        end
    end

    // Milliwatt phase steps once per frame, after the last channel
    always_ff @(posedge clk) begin
        if (rst) begin
            milliwatt_phase <= 3'h0;
        end else if (slot_in.valid && slot_in.channel == rxpc_pkg::LAST_CHANNEL) begin
            milliwatt_phase <= milliwatt_phase + 3'h1;
        end
    end

    // Clock gate latched per slot so a pulse is never cut mid-channel
    always_ff @(posedge clk) begin
        if (rst) begin
            clock_gate <= 1'b1;
        end else if (slot_in.valid) begin
            clock_gate <= !fractional_mode || !per_channel_enable
                          || cfg[rxpc_pkg::BIT_CLK_ENABLE];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rx_serial_clock_out <= 1'b0;
        end else begin
            // Latched gate only counts in fractional mode with enable set
            rx_serial_clock_out <= rx_bit_clock_in
                                   && (clock_gate || !fractional_mode || !per_channel_enable);
        end
    end

endmodule : rxpc_conditioner

// ### sim/rxpc_far_model.sv
// Far side model: pattern generator and receive bit clock source
`timescale 1ns/10ps
module rxpc_far_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       generator_take,
    output logic [7:0]      generator_data,
    output logic            rx_bit_clock_in
);
    logic [1:0] div;
    // Advances only on a consumed byte, so marked channels see one stream
    always_ff @(posedge clk) begin
        if (rst) begin
            generator_data <= 8'hc0;
        end else if (generator_take) begin
            generator_data <= generator_data + 8'h01;
        end
    end
    // Bit clock at a quarter of the system rate
    always_ff @(posedge clk) begin
        div <= rst ? 2'h0 : div + 2'h1;
    end
    assign rx_bit_clock_in = div[1];
endmodule : rxpc_far_model

// ### sim/rxpc_conditioner_monitor.sv
// Port checker for the receive payload conditioner
`timescale 1ns/10ps
module rxpc_conditioner_monitor (
    input wire logic                 clk,
    input wire logic                 rst,
    input wire rxpc_pkg::rxpc_bus_t  bus_req,
    input wire logic [7:0]           bus_rdata,
    input wire rxpc_pkg::rxpc_slot_t slot_in,
    input wire rxpc_pkg::rxpc_slot_t slot_out,
    input wire logic                 rx_pattern_source_sel,
    input wire logic                 detector_valid,
    input wire logic [7:0]           detector_data,
    input wire logic [7:0]           generator_data,
    input wire logic                 generator_take,
    input wire logic                 fractional_mode,
    input wire logic                 rx_bit_clock_in,
    input wire logic                 rx_serial_clock_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_slot_latency: assert property (!$past(rst) |-> slot_out.valid == $past(slot_in.valid))
        else $error("slot latency wrong");
    a_detect_copy: assert property (detector_valid |-> slot_out.data == detector_data
        && detector_data == $past(slot_in.data)) else $error("extracted byte wrong");
    a_detect_source: assert property (detector_valid |-> !$past(rx_pattern_source_sel))
        else $error("extraction with generator selected");
    a_gen_take: assert property (generator_take |-> slot_in.valid && rx_pattern_source_sel)
        else $error("generator taken wrongly");
    a_gen_insert: assert property (generator_take |=> slot_out.data == $past(generator_data)
        && !detector_valid) else $error("generator byte not inserted");
    a_clock_free: assert property (!$past(rst) && !$past(fractional_mode)
        |-> rx_serial_clock_out == $past(rx_bit_clock_in)) else $error("clock gated outside mode");
    a_clock_gated: assert property (rx_serial_clock_out |-> $past(rx_bit_clock_in))
        else $error("clock pulse without input");
    a_busy_early: assert property ((bus_req.wr && bus_req.addr == rxpc_pkg::ADDR_ADDR_CTRL
        && bus_req.wdata[6:0] inside {[7'h01:7'h48]}) ##2 (bus_req.rd
        && bus_req.addr == rxpc_pkg::ADDR_STATUS) |=> bus_rdata[7]) else $error("busy late");
    a_status_reserved: assert property (bus_req.rd && bus_req.addr == rxpc_pkg::ADDR_STATUS
        |=> bus_rdata[6:0] == 7'h00) else $error("status reserved bits set");
endmodule : rxpc_conditioner_monitor
bind rxpc_conditioner rxpc_conditioner_monitor u_rxpc_conditioner_monitor (.clk, .rst, .bus_req,
    .bus_rdata, .slot_in, .slot_out, .rx_pattern_source_sel, .detector_valid, .detector_data,
    .generator_data, .generator_take, .fractional_mode, .rx_bit_clock_in, .rx_serial_clock_out);

// ### sim/tb.sv
// Self-checking bench for the receive payload conditioner
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb;
    logic                 clk;
    logic                 rst;
    rxpc_pkg::rxpc_bus_t  bus_req;
    logic [7:0]           bus_rdata;
    rxpc_pkg::rxpc_slot_t slot_in;
    rxpc_pkg::rxpc_slot_t slot_out;
    logic                 rx_pattern_source_sel;
    logic                 detector_valid;
    logic [7:0]           detector_data;
    logic [7:0]           generator_data;
    logic                 generator_take;
    logic                 fractional_mode;
    logic                 rx_bit_clock_in;
    logic                 rx_serial_clock_out;
    int                   mismatches;
    int                   n_checks;
    int                   cycles;
    logic [7:0]           v;
    logic [7:0]           cfg [10] = '{8'h00, 8'h10, 8'h80, 8'h90, 8'h40, 8'h60, 8'h03, 8'h82,
                                       8'h08, 8'h20};
    logic [7:0]           exp_d [10] = '{8'h54, 8'hd4, 8'hab, 8'h2b, 8'h3c, 8'h5a, 8'h55, 8'haa,
                                         8'h54, 8'h1e};
    rxpc_conditioner u_rxpc_conditioner (.clk, .rst, .bus_req, .bus_rdata, .slot_in, .slot_out,
        .rx_pattern_source_sel, .detector_valid, .detector_data, .generator_data,
        .generator_take, .fractional_mode, .rx_bit_clock_in, .rx_serial_clock_out);
    rxpc_far_model u_rxpc_far_model (.clk, .rst, .generator_take, .generator_data,
        .rx_bit_clock_in);
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict
    // Generous ceiling: the whole sequence needs a few thousand cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            give_verdict();
        end
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_req <= '{1'b1, 1'b0, a, d};
        @(posedge clk);
        bus_req <= '0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        bus_req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk);
        bus_req <= '0;
        #1 d = bus_rdata;
    endtask : rd
    task automatic wait_idle;
        for (int i = 0; i < 100; i++) begin
            rd(rxpc_pkg::ADDR_STATUS, v);
            if (v[7] === 1'b0) break;
        end
        `CHK("busy clear", 1'b0, v[7])
    endtask : wait_idle
    task automatic iw(input logic [6:0] a, input logic [7:0] d);
        wr(rxpc_pkg::ADDR_DATA_BUF, d);
        wr(rxpc_pkg::ADDR_ADDR_CTRL, {1'b0, a});
        wait_idle();
    endtask : iw
    task automatic send(input logic [4:0] ch, input logic [7:0] ed, input logic [3:0] es);
        @(posedge clk);
        slot_in <= '{1'b1, ch, 8'h54, 4'h6};
        @(posedge clk);
        slot_in.valid <= 1'b0;
        #1;
        `CHK("slot data", ed, slot_out.data)
        `CHK("slot sig", es, slot_out.signaling)
    endtask : send
    initial begin
        rst = 1'b1;
        bus_req = '0;
        slot_in = '0;
        rx_pattern_source_sel = 1'b0;
        fractional_mode = 1'b0;
        mismatches = 0;
        n_checks = 0;
        cycles = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rd(rxpc_pkg::ADDR_STATUS, v); `CHK("status", 8'h00, v)
        rd(rxpc_pkg::ADDR_ADDR_CTRL, v); `CHK("addr ctrl", 8'h00, v)
        rd(rxpc_pkg::ADDR_DATA_BUF, v); `CHK("data buf", 8'h00, v)
        $display("test reset done");
        wr(rxpc_pkg::ADDR_DATA_BUF, 8'ha5);
        wr(rxpc_pkg::ADDR_ADDR_CTRL, {1'b0, rxpc_pkg::IND_TRUNK_FIRST});
        rd(rxpc_pkg::ADDR_STATUS, v); `CHK("busy early", 8'h80, v)
        repeat (116) @(posedge clk);
        rd(rxpc_pkg::ADDR_STATUS, v); `CHK("busy held", 8'h80, v)
        wr(rxpc_pkg::ADDR_DATA_BUF, 8'h11);
        repeat (7) @(posedge clk);
        rd(rxpc_pkg::ADDR_STATUS, v); `CHK("busy done", 8'h00, v)
        rd(rxpc_pkg::ADDR_DATA_BUF, v); `CHK("refused buf", 8'ha5, v)
        wr(rxpc_pkg::ADDR_ADDR_CTRL, {1'b1, rxpc_pkg::IND_TRUNK_FIRST});
        wait_idle();
        rd(rxpc_pkg::ADDR_DATA_BUF, v); `CHK("read back", 8'ha5, v)
        wr(rxpc_pkg::ADDR_ADDR_CTRL, 8'h49);
        rd(rxpc_pkg::ADDR_STATUS, v); `CHK("bad addr", 8'h00, v)
        $display("test access done");
        for (int i = 0; i < 10; i++) iw(7'(rxpc_pkg::IND_CFG_FIRST + i), cfg[i]);
        iw(7'(rxpc_pkg::IND_TRUNK_FIRST + 4), 8'h3c);
        iw(7'(rxpc_pkg::IND_TRUNK_FIRST + 5), 8'h5a);
        iw(rxpc_pkg::IND_SIG_FIRST, 8'h8b);
        for (int i = 0; i < 10; i++) send(5'(i), 8'h54, 4'h6);
        wr(rxpc_pkg::ADDR_CONFIG, 8'h01);
        for (int i = 0; i < 10; i++) begin
            send(5'(i), exp_d[i], (i == 0) ? 4'hb : 4'h6);
            `CHK("detector", (i == 8), detector_valid)
        end
        `CHK("detector data", 8'h54, detector_data)
        $display("test conditioning done");
        rx_pattern_source_sel <= 1'b1;
        fractional_mode <= 1'b1;
        iw(7'(rxpc_pkg::IND_CFG_FIRST + 10), 8'h0c);
        iw(7'(rxpc_pkg::IND_CFG_FIRST + 12), 8'h08);
        send(5'd10, 8'hc0, 4'h6);
        send(5'd11, 8'h54, 4'h6);
        send(5'd12, 8'hc1, 4'h6);
        v = 8'h00;
        repeat (8) begin
            @(posedge clk);
            #1 v[0] = v[0] | rx_serial_clock_out;
        end
        `CHK("gated clock", 1'b0, v[0])
        fractional_mode <= 1'b0;
        $display("test generator done");
        give_verdict();
    end
endmodule : tb
